// >>> rtl/gbmc_cfg.svh
`ifndef GBMC_CFG_SVH
`define GBMC_CFG_SVH

// Register byte offsets
`define GBMC_OFS_CMD       12'h000
`define GBMC_OFS_ADDR      12'h004
`define GBMC_OFS_ROLE      12'h008
`define GBMC_OFS_STATUS    12'h00c
`define GBMC_OFS_INTEN     12'h010
`define GBMC_OFS_INTSTAT   12'h014
`define GBMC_OFS_HANDLER   12'h018

// Command register fields
`define GBMC_CMD_OP_LSB    0
`define GBMC_CMD_OP_MSB    2
`define GBMC_CMD_SEL_BIT   3

// Role register fields
`define GBMC_ROLE_SC_BIT   0
`define GBMC_ROLE_AC_BIT   1

// Interrupt enable: service request bit
`define GBMC_INT_SRQ_BIT   1

// Reset values
`define GBMC_INTEN_RST     32'h0000_0000
`define GBMC_ROLE_RST      2'h3

// Timing: length of a bus message strobe, in cycles
`define GBMC_MSG_CYCLES    8'h04
// Interface clear pulse: at least 100 us
`define GBMC_IFC_TIME_US   100
`define GBMC_CLK_MHZ       10

`endif

// >>> rtl/gbmc_pkg.sv
package gbmc_pkg;

   typedef enum logic [2:0] {
      GBMC_OP_NONE,
      GBMC_OP_ABORT,
      GBMC_OP_REMOTE,
      GBMC_OP_LOCKOUT,
      GBMC_OP_LOCAL,
      GBMC_OP_TRIGGER,
      GBMC_OP_CLEAR
   } gbmc_op_t;

   typedef struct packed {
      logic        ifc;
      logic        ren;
      logic        llo;
      logic        gtl;
      logic        get;
      logic        dcl;
      logic        sel;
      logic [30:0] targets;
   } gbmc_bus_t;

   typedef struct packed {
      logic active;
      logic system;
   } gbmc_role_t;

endpackage

// >>> rtl/gbmc_sync.sv
`timescale 1ns/10ps

module gbmc_sync (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Data
   input  wire logic din,
   output logic      dout
);

   logic stage1;

   // Only the second stage is read downstream
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= 1'b0;
         dout   <= 1'b0;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end

endmodule

// >>> rtl/gbmc_timer.sv
`timescale 1ns/10ps

module gbmc_timer #(
   parameter int W = 12
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Control
   input  wire logic         start,
   input  wire logic [W-1:0] length,
   output logic              busy
);

   logic [W-1:0] count;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
      end else if (start) begin
         count <= length;
      end else if (count != '0) begin
         count <= count - 1'b1;
      end
   end

   assign busy = (count != '0);

endmodule

// >>> rtl/gbmc_ctrl.sv
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "gbmc_cfg.svh"

module gbmc_ctrl #(
   parameter int TARGETS = 31
) (
   // APB slave
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Instrument bus
   input  wire logic                  srq_pin,
   output gbmc_pkg::gbmc_bus_t        bus,
   // Service request to the processor
   output logic                       srq_irq
);

   localparam int IFC_CYC_I = (`GBMC_IFC_TIME_US * `GBMC_CLK_MHZ);
   localparam logic [11:0] IFC_CYC = IFC_CYC_I[11:0];

   function automatic logic is_op(input logic [31:0] d, input gbmc_pkg::gbmc_op_t op);
      is_op = (d[`GBMC_CMD_OP_MSB:`GBMC_CMD_OP_LSB] == 3'(op));
   endfunction

   gbmc_pkg::gbmc_role_t role;
   logic [30:0]          targets;
   logic [31:0]          inten;
   logic                 handler;
   logic                 srq_pend;
   logic                 err;
   logic                 remote;
   logic                 lockout;
   logic                 srq_s;
   logic                 ifc_busy;
   logic                 msg_busy;
   logic                 ifc_start;
   logic                 msg_start;
   logic                 boot;
   logic                 wr;
   logic                 rd_err;
   logic                 cmd_wr;
   logic                 sel;
   logic                 allowed;
   logic [2:0]           op;
   logic [5:0]           pulse;
   logic [5:0]           next_pulse;

   assign wr     = psel && penable && pwrite;
   assign cmd_wr = wr && (paddr == `GBMC_OFS_CMD);
   assign op     = pwdata[`GBMC_CMD_OP_MSB:`GBMC_CMD_OP_LSB];
   assign sel    = pwdata[`GBMC_CMD_SEL_BIT];
   assign pready = 1'b1;

   gbmc_sync u_srq_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (srq_pin),
      .dout    (srq_s)
   );

   // Role checks per message type
   always_comb begin
      allowed    = 1'b0;
      next_pulse = 6'h00;
      unique case (op)
         3'(gbmc_pkg::GBMC_OP_ABORT): begin
            allowed = (role.active || role.system) && !sel;
         end
         3'(gbmc_pkg::GBMC_OP_REMOTE): begin
            allowed       = role.system;
            next_pulse[0] = 1'b1;
         end
         3'(gbmc_pkg::GBMC_OP_LOCKOUT): begin
            allowed       = role.active && !sel;
            next_pulse[1] = 1'b1;
         end
         3'(gbmc_pkg::GBMC_OP_LOCAL): begin
            allowed       = sel ? role.active : role.system;
            next_pulse[2] = 1'b1;
         end
         3'(gbmc_pkg::GBMC_OP_TRIGGER): begin
            allowed       = role.active;
            next_pulse[3] = 1'b1;
         end
         3'(gbmc_pkg::GBMC_OP_CLEAR): begin
            allowed       = role.active;
            next_pulse[4] = 1'b1;
         end
         default: begin
            allowed = 1'b0;
         end
      endcase
   end

   // Busy bus refuses new commands too, so messages never overlap
   assign ifc_start = cmd_wr && allowed && !msg_busy && !ifc_busy && is_op(pwdata, gbmc_pkg::GBMC_OP_ABORT);
   assign msg_start = cmd_wr && allowed && !msg_busy && !ifc_busy && !is_op(pwdata, gbmc_pkg::GBMC_OP_ABORT);

   gbmc_timer #(.W(12)) u_ifc (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (ifc_start),
      .length  (IFC_CYC),
      .busy    (ifc_busy)
   );

   gbmc_timer #(.W(8)) u_msg (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (msg_start),
      .length  (`GBMC_MSG_CYCLES),
      .busy    (msg_busy)
   );

   // Software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         targets <= '0;
         inten   <= `GBMC_INTEN_RST;
         handler <= 1'b0;
      end else if (wr) begin
         if (paddr == `GBMC_OFS_ADDR) begin
            targets <= pwdata[30:0];
         end
         if (paddr == `GBMC_OFS_INTEN) begin
            inten <= pwdata;
         end
         if (paddr == `GBMC_OFS_HANDLER) begin
            handler <= pwdata[0];
         end
      end
   end

   // Role: system controller holds active role after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         role <= `GBMC_ROLE_RST;
      end else if (ifc_start && role.system) begin
         role.active <= 1'b1;
      end else if (wr && paddr == `GBMC_OFS_ROLE) begin
         role.system <= pwdata[`GBMC_ROLE_SC_BIT];
         role.active <= pwdata[`GBMC_ROLE_AC_BIT];
      end
   end

   // Refused command error, sticky until written with one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err <= 1'b0;
      end else if (cmd_wr && !allowed) begin
         err <= 1'b1;
      end else if (wr && paddr == `GBMC_OFS_STATUS && pwdata[0]) begin
         err <= 1'b0;
      end
   end

   // Remote and lockout state; boot raises remote once after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot    <= 1'b1;
         remote  <= 1'b0;
         lockout <= 1'b0;
      end else begin
         boot <= 1'b0;
         if (boot || ifc_start) begin
            remote <= 1'b1;
         end else if (msg_start && next_pulse[0]) begin
            remote <= 1'b1;
         end else if (msg_start && next_pulse[2] && !sel) begin
            remote  <= 1'b0;
            lockout <= 1'b0;
         end
         if (msg_start && next_pulse[1]) begin
            lockout <= 1'b1;
         end
      end
   end

   // Bus strobes held for the message length
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse <= 6'h00;
         bus   <= '0;
      end else begin
         if (msg_start) begin
            pulse <= next_pulse;
         end else if (!msg_busy) begin
            pulse <= 6'h00;
         end
         bus.ifc <= ifc_busy;
         bus.ren <= remote;
         bus.llo <= lockout;
         // Gated by the timer so each strobe stands exactly the message length
         bus.gtl <= pulse[2] && msg_busy;
         bus.get <= pulse[3] && msg_busy;
         bus.dcl <= pulse[4] && msg_busy;
         if (msg_start) begin
            bus.sel     <= sel;
            bus.targets <= sel ? targets : '0;
         end else if (!msg_busy) begin
            bus.sel     <= 1'b0;
            bus.targets <= '0;
         end
      end
   end

   // Service request: synchronised level, one pending at a time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         srq_pend <= 1'b0;
      end else if (!srq_pend && srq_s && inten[`GBMC_INT_SRQ_BIT] && handler) begin
         srq_pend <= 1'b1;
      end else if (wr && paddr == `GBMC_OFS_INTSTAT && pwdata[`GBMC_INT_SRQ_BIT]) begin
         srq_pend <= 1'b0;
      end
   end

   assign srq_irq = srq_pend;

   // Read mux; unmapped offsets read zero with slave error
   assign rd_err = !(paddr == `GBMC_OFS_CMD || paddr == `GBMC_OFS_ADDR || paddr == `GBMC_OFS_ROLE ||
                     paddr == `GBMC_OFS_STATUS || paddr == `GBMC_OFS_INTEN ||
                     paddr == `GBMC_OFS_INTSTAT || paddr == `GBMC_OFS_HANDLER);
   assign pslverr = psel && penable && rd_err;

   always_comb begin
      prdata = 32'h0000_0000;
      unique case (paddr)
         `GBMC_OFS_ADDR:    prdata = {1'b0, targets};
         `GBMC_OFS_ROLE:    prdata = {30'h0, role.active, role.system};
         `GBMC_OFS_STATUS:  prdata = {26'h0, srq_s, lockout, remote, msg_busy, ifc_busy, err};
         `GBMC_OFS_INTEN:   prdata = inten;
         `GBMC_OFS_INTSTAT: prdata = {30'h0, srq_pend, 1'b0};
         `GBMC_OFS_HANDLER: prdata = {31'h0, handler};
         default:           prdata = 32'h0000_0000;
      endcase
   end

endmodule

// >>> test/gbmc_props.sv
`timescale 1ns/10ps

module gbmc_props #(
   parameter int TARGETS = 31
) (
   // Clock and reset
   input wire logic                pclk,
   input wire logic                presetn,
   // APB
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [11:0]         paddr,
   input wire logic [31:0]         pwdata,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   // Instrument bus
   input wire logic                srq_pin,
   input wire gbmc_pkg::gbmc_bus_t bus,
   input wire logic                srq_irq
);
   logic       cmdw;
   logic       idle;
   logic [2:0] op;
   logic [1:0] role_q;

   assign cmdw = psel && penable && pwrite && pready && paddr == 12'h000;
   assign op   = pwdata[2:0];
   assign idle = !(bus.ifc || bus.gtl || bus.get || bus.dcl);

   // Role shadow, so that refusals can be predicted without seeing inside
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) role_q <= 2'h3;
      else if (psel && penable && pwrite && paddr == 12'h008) role_q <= pwdata[1:0];
      else if (cmdw && op == 3'h1 && !pwdata[3] && role_q[0]) role_q[1] <= 1'b1;
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_trig_get: assert property (
      cmdw && op == 3'h5 && role_q[1] && idle |-> ##2 bus.get) else $error("trigger missing");
   chk_get_width: assert property (
      $rose(bus.get) |-> bus.get [*4] ##1 !bus.get) else $error("trigger width");
   chk_abort_ifc: assert property (
      cmdw && op == 3'h1 && !pwdata[3] && role_q != 2'h0 && idle |-> ##2 (bus.ifc && bus.ren))
      else $error("abort missing");
   chk_abort_sel: assert property (
      cmdw && op == 3'h1 && pwdata[3] && idle |-> ##1 !bus.ifc ##1 !bus.ifc) else $error("abort not refused");
   chk_llo_role: assert property (
      cmdw && op == 3'h3 && !role_q[1] |-> ##1 $stable(bus.llo) ##1 $stable(bus.llo))
      else $error("lockout without role");
   chk_abort_llo: assert property (
      $rose(bus.ifc) && $past(bus.llo, 2) |-> bus.llo) else $error("abort dropped lockout");
   chk_local_all: assert property (
      cmdw && op == 3'h4 && !pwdata[3] && role_q[0] && idle |-> ##[1:3] !(bus.llo || bus.ren))
      else $error("local all failed");
   chk_irq_hold: assert property (
      srq_irq && !(psel && penable && pwrite && paddr == 12'h014 && pwdata[1]) |=> srq_irq)
      else $error("pending lost");
endmodule

// >>> test/gbmc_inst_model.sv
`timescale 1ns/10ps

module gbmc_inst_model (
   // Clock and reset
   input wire logic                pclk,
   input wire logic                presetn,
   // Bench controls
   input wire logic                need,
   input wire logic                key,
   // Instrument bus
   input wire gbmc_pkg::gbmc_bus_t bus,
   output logic                    srq_pin,
   output logic                    remote
);
   // No poll exists here, so a device clear stands in as acknowledgement
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) srq_pin <= 1'b0;
      else if (bus.ifc || bus.dcl) srq_pin <= 1'b0;
      else if (need) srq_pin <= 1'b1;
   end

   // One device stands for all instruments
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) remote <= 1'b0;
      else if (!bus.ren || (key && !bus.llo)) remote <= 1'b0;
      else if ($rose(bus.ren) || bus.sel) remote <= 1'b1;
   end
endmodule

// >>> test/gbmc_ctrl_bench.sv
`timescale 1ns/10ps

module gbmc_ctrl_bench;
   logic                pclk    = 1'b0;
   logic                presetn = 1'b0;
   logic                psel    = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite  = 1'b0;
   logic [11:0]         paddr   = 12'h000;
   logic [31:0]         pwdata  = 32'h0;
   logic                need    = 1'b0;
   logic                key     = 1'b0;
   logic [31:0]         prdata, rd;
   logic                pready, pslverr, srq_pin, srq_irq, remote, serr;
   gbmc_pkg::gbmc_bus_t bus;
   int                  fail_count = 0;
   int                  tests_run  = 0;
   // Entries: role, command, expected error
   localparam logic [6:0] TAB [11] = '{7'h03, 7'h45, 7'h27, 7'h49, 7'h39, 7'h3d, 7'h2d, 7'h24, 7'h58, 7'h5c, 7'h22};

   always #50 pclk = ~pclk;

   gbmc_ctrl #(.TARGETS(31)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .srq_pin, .bus, .srq_irq);
   gbmc_inst_model inst (.pclk, .presetn, .need, .key, .bus, .srq_pin, .remote);

   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic give_up;
      fail_count++;
      summarize();
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) give_up();
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic cmd(input logic [3:0] c);
      apb(1'b1, 12'h000, {28'h0, c});
   endtask

   // Busy bits must clear before the next command is accepted
   task automatic wait_idle;
      for (int i = 0; i < 600; i++) begin
         apb(1'b0, 12'h00c, 32'h0);
         if (rd[2:1] === 2'b00) return;
      end
      give_up();
   endtask

   task automatic wait_irq;
      for (int i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (srq_irq === 1'b1) return;
      end
      give_up();
   endtask

   task automatic t_regs;
      apb(1'b0, 12'h010, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      check(rd & 32'h3, 32'h3);
      apb(1'b0, 12'h020, 32'h0);
      check({31'h0, serr}, 32'h1);
      wait_idle();
      check(rd & 32'h8, 32'h8);
   endtask

   task automatic t_trigger;
      apb(1'b1, 12'h004, 32'h5);
      cmd(4'hd);
      repeat (2) @(posedge pclk);
      #1;
      check({bus.sel, bus.targets}, {1'b1, 31'h5});
      check({31'h0, bus.get}, 32'h1);
      wait_idle();
      cmd(4'h5);
      repeat (2) @(posedge pclk);
      #1;
      check({31'h0, bus.sel}, 32'h0);
      wait_idle();
   endtask

   task automatic t_lockout;
      cmd(4'h3);
      wait_idle();
      check(rd & 32'h10, 32'h10);
      @(posedge pclk);
      key <= 1'b1;
      @(posedge pclk);
      key <= 1'b0;
      repeat (2) @(posedge pclk);
      check({31'h0, remote}, 32'h1);
      cmd(4'h1);
      wait_idle();
      check(rd & 32'h18, 32'h18);
      cmd(4'h4);
      wait_idle();
      check(rd & 32'h18, 32'h0);
   endtask

   task automatic t_roles;
      foreach (TAB[i]) begin
         apb(1'b1, 12'h008, {30'h0, TAB[i][6:5]});
         cmd(TAB[i][4:1]);
         wait_idle();
         check(rd & 32'h1, {31'h0, TAB[i][0]});
         apb(1'b1, 12'h00c, 32'h1);
      end
      apb(1'b0, 12'h008, 32'h0);
      check(rd & 32'h3, 32'h3);
      cmd(4'h9);
      repeat (3) @(posedge pclk);
      #1;
      check({31'h0, bus.ifc}, 32'h0);
   endtask

   task automatic t_srq;
      apb(1'b1, 12'h018, 32'h1);
      @(posedge pclk);
      need <= 1'b1;
      @(posedge pclk);
      need <= 1'b0;
      repeat (10) @(posedge pclk);
      check({31'h0, srq_irq}, 32'h0);
      apb(1'b1, 12'h018, 32'h0);
      apb(1'b1, 12'h010, 32'h2);
      repeat (10) @(posedge pclk);
      check({31'h0, srq_irq}, 32'h0);
      apb(1'b1, 12'h018, 32'h1);
      wait_irq();
      apb(1'b1, 12'h014, 32'h2);
      repeat (6) @(posedge pclk);
      check({31'h0, srq_irq}, 32'h1);
      cmd(4'h6);
      wait_idle();
      apb(1'b1, 12'h014, 32'h2);
      repeat (6) @(posedge pclk);
      check({31'h0, srq_irq}, 32'h0);
   endtask

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_trigger();
      t_lockout();
      t_roles();
      t_srq();
      summarize();
   end
endmodule

bind gbmc_ctrl gbmc_props #(.TARGETS(TARGETS)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .srq_pin(srq_pin), .bus(bus), .srq_irq(srq_irq));
